//--- logic/dctc_pkg.sv
// Purpose: shared constants for the dual cascadable timer control block
// Assumes: one 25 MHz clock that also serves as the high-frequency timer clock
// Notes: register map, control field layout, mode and clock-select encodings
package dctc_pkg;

  // register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte offsets, one aligned word each
  localparam logic [7:0] OFS_A_CONTROL = 8'h00;
  localparam logic [7:0] OFS_A_PERIOD = 8'h04;
  localparam logic [7:0] OFS_A_PULSE_WIDTH = 8'h08;
  localparam logic [7:0] OFS_B_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_B_PERIOD = 8'h10;
  localparam logic [7:0] OFS_B_PULSE_WIDTH = 8'h14;
  localparam logic [7:0] OFS_INT_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1C;
  localparam logic [7:0] OFS_GLOBAL_CFG = 8'h20;
  localparam logic [7:0] OFS_COUNT_STATE = 8'h24;

  // control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_RUN_BIT = 3;
  localparam int CTL_CK_LSB = 4;
  localparam int CTL_FF_BIT = 7;

  // global config and interrupt bit positions
  localparam int GCFG_HALF_BIT = 0;
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;
  localparam int CNT_FF_A_BIT = 16;
  localparam int CNT_FF_B_BIT = 17;

  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // mode field codes
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_DIVOUT = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_CASCADE = 3'h3;
  localparam logic [2:0] MODE16_TIMER = 3'h4;
  localparam logic [2:0] MODE16_WARMUP = 3'h5;
  localparam logic [2:0] MODE16_PWM = 3'h6;
  localparam logic [2:0] MODE16_PULSEGEN = 3'h7;

  // clock-select codes
  localparam logic [2:0] CK_SLOWEST = 3'h0;
  localparam logic [2:0] CK_SLOW = 3'h1;
  localparam logic [2:0] CK_FAST = 3'h2;
  localparam logic [2:0] CK_FASTEST = 3'h3;
  localparam logic [2:0] CK_PIN = 3'h7;

  // prescaler: tick k is high_freq_clock / 2^(k+TICK_EXP_LO)
  localparam int PRESC_W = 13;
  localparam int TICK_EXP_LO = 3;
  localparam int TICK_N = 10;
  localparam int TICK_IDX_SLOWEST = 11 - TICK_EXP_LO;
  localparam int TICK_IDX_SLOW = 7 - TICK_EXP_LO;
  localparam int TICK_IDX_FAST = 5 - TICK_EXP_LO;
  localparam int TICK_IDX_FASTEST = 3 - TICK_EXP_LO;

  // wrap points of the up-counters
  localparam logic [15:0] TOP8 = 16'h00FF;
  localparam logic [15:0] TOP16 = 16'hFFFF;

endpackage

//--- logic/dctc_tick_if.sv
// Purpose: carries prescaler enable pulses to the timer core
// Assumes: all pulses are one clock cycle wide, same clock domain
// Notes: bit k is high for one cycle every 2^(k+3) cycles
`timescale 1ns/1ps
interface dctc_tick_if;
  logic [dctc_pkg::TICK_N-1:0] tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

//--- logic/dctc_prescaler.sv
// Purpose: free-running divider of the high-frequency clock
// Assumes: clock is the high-frequency timer clock
// Notes: every tap is a one-cycle enable, never a derived clock
`timescale 1ns/1ps
module dctc_prescaler (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // enable pulses out
  dctc_tick_if.src tk
);

  typedef struct packed {
    logic [dctc_pkg::PRESC_W-1:0] cnt;
  } dctc_presc_t;

  dctc_presc_t st_q;
  dctc_presc_t st_d;

  // divider just advances; taps share it so they stay phase aligned
  always_comb begin
    st_d = st_q;
    st_d.cnt = st_q.cnt + 13'h0001;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // tap k fires when the low k+3 bits are all ones
  for (genvar k = 0; k < dctc_pkg::TICK_N; k++) begin : g_tap
    assign tk.tick[k] = &st_q.cnt[k+dctc_pkg::TICK_EXP_LO-1:0];
  end

endmodule

//--- logic/dctc_pin_sync.sv
// Purpose: brings an external event pin into the clock domain
// Assumes: pin pulses last longer than two clock periods
// Notes: rise is a one-cycle pulse per rising edge of the pin
`timescale 1ns/1ps
module dctc_pin_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // pin in, edge out
  input wire logic pin,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } dctc_sync_t;

  dctc_sync_t st_q;
  dctc_sync_t st_d;

  // s1 feeds only s2; the edge looks at s2 and s3
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = st_q.s2 & ~st_q.s3;

endmodule

//--- logic/dctc_top.sv
// Purpose: two 8-bit timer/counter channels, cascadable to one 16-bit counter
// Assumes: software keeps compare values legal and fields stable while running
// Notes: clock doubles as the high-frequency clock; pins are synchronised
//
// Summary of operation
// [RL1] channel a: control, period, pulse-width registers
// [RL2] channel b: control, period, pulse-width registers
// [RL3] period register not rewritten while running
// [RL4] a pulse width changes running only in PWM
// [RL5] b pulse width changes running only in PWM
// [RL6] clock select picks prescaler tap or pin
// [RL7] run 0 stops and clears, 1 counts
// [RL8] channel a mode decode, top bit reserved
// [RL9] cascade: a mode 011, sub-mode from b
// [RL10] cascade: a clock, b run and flip-flop
// [RL11] flip-flop control bit presets output level
// [RL12] mode, clock, flip-flop fixed while running
// [RL13] stop write keeps fields; start may set
// [RL14] timer match raises interrupt, clears, continues
// [RL15] channel b mode decode including 16-bit modes
// [RL16] period 1..255, PWM width 2..254
// [RL17] 8-bit counters, b is cascaded upper byte
`timescale 1ns/1ps
module dctc_top (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [dctc_pkg::ADDR_W-1:0] addr,
  input wire logic [dctc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [dctc_pkg::DATA_W-1:0] rdata,
  // event pins
  input wire logic channel_a_pin,
  input wire logic channel_b_pin,
  // timer flip-flop outputs
  output logic channel_a_out,
  output logic channel_b_out,
  // interrupt
  output logic irq
);

  // behaviour class chosen from a mode field
  typedef enum logic [2:0] {
    DCTC_IDLE = 3'h0,
    DCTC_TIMER = 3'h1,
    DCTC_DIVOUT = 3'h3,
    DCTC_PWM = 3'h2,
    DCTC_PULSEGEN = 3'h6
  } dctc_kind_t;

  // result of one counting step
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] shd;
    logic ff;
    logic irq;
  } dctc_step_t;

  // whole block state
  typedef struct packed {
    logic [7:0] a_control;
    logic [7:0] a_period;
    logic [7:0] a_pulse_width;
    logic [7:0] b_control;
    logic [7:0] b_period;
    logic [7:0] b_pulse_width;
    logic [7:0] a_shadow;
    logic [7:0] b_shadow;
    logic [7:0] a_cnt;
    logic [7:0] b_cnt;
    logic a_ff;
    logic b_ff;
    logic half;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [dctc_pkg::DATA_W-1:0] rdata;
    logic irq;
  } dctc_state_t;

  dctc_state_t st_q;
  dctc_state_t st_d;

  dctc_tick_if tk ();
  logic pin_a_rise;
  logic pin_b_rise;

  // prescaler taps
  dctc_prescaler u_presc (
    .clock(clock),
    .rstn(rstn),
    .tk(tk)
  );

  // external event pins, three flops each
  dctc_pin_sync u_sync_a (
    .clock(clock),
    .rstn(rstn),
    .pin(channel_a_pin),
    .rise(pin_a_rise)
  );

  dctc_pin_sync u_sync_b (
    .clock(clock),
    .rstn(rstn),
    .pin(channel_b_pin),
    .rise(pin_b_rise)
  );

  // source clock enable from a clock-select code
  function automatic logic pick_tick(input logic [2:0] ck, input logic half,
                                     input logic [dctc_pkg::TICK_N-1:0] tick, input logic pin_rise);
    logic r;
    r = 1'b0;
    case (ck)
      dctc_pkg::CK_SLOWEST: r = half ? tick[dctc_pkg::TICK_IDX_SLOWEST+1] : tick[dctc_pkg::TICK_IDX_SLOWEST];
      dctc_pkg::CK_SLOW: r = half ? tick[dctc_pkg::TICK_IDX_SLOW+1] : tick[dctc_pkg::TICK_IDX_SLOW];
      dctc_pkg::CK_FAST: r = half ? tick[dctc_pkg::TICK_IDX_FAST+1] : tick[dctc_pkg::TICK_IDX_FAST];
      dctc_pkg::CK_FASTEST: r = half ? tick[dctc_pkg::TICK_IDX_FASTEST+1] : tick[dctc_pkg::TICK_IDX_FASTEST];
      dctc_pkg::CK_PIN: r = pin_rise;
      default: r = 1'b0; // codes 100..110 unused: counter stands
    endcase
    return r;
  endfunction

  // 8-bit mode field to behaviour; reserved codes leave the channel idle
  function automatic dctc_kind_t kind8(input logic [2:0] mode);
    dctc_kind_t k;
    k = DCTC_IDLE;
    case (mode)
      dctc_pkg::MODE_TIMER: k = DCTC_TIMER;
      dctc_pkg::MODE_DIVOUT: k = DCTC_DIVOUT;
      dctc_pkg::MODE_PWM: k = DCTC_PWM;
      default: k = DCTC_IDLE;
    endcase
    return k;
  endfunction

  // 16-bit sub-mode taken from channel b's field
  function automatic dctc_kind_t kind16(input logic [2:0] mode);
    dctc_kind_t k;
    k = DCTC_IDLE;
    case (mode)
      dctc_pkg::MODE16_TIMER: k = DCTC_TIMER;
      dctc_pkg::MODE16_WARMUP: k = DCTC_TIMER;
      dctc_pkg::MODE16_PWM: k = DCTC_PWM;
      dctc_pkg::MODE16_PULSEGEN: k = DCTC_PULSEGEN;
      default: k = DCTC_IDLE; // 8-bit codes make no sense cascaded
    endcase
    return k;
  endfunction

  // one step of an up-counter, shared by 8-bit and cascaded use
  function automatic dctc_step_t step(input dctc_kind_t kind, input logic run, input logic tick,
                                      input logic [15:0] top, input logic [15:0] cnt,
                                      input logic [15:0] per, input logic [15:0] pw,
                                      input logic [15:0] shd, input logic ff, input logic ffctl);
    dctc_step_t r;
    logic [15:0] nxt;
    r.cnt = cnt;
    r.shd = shd;
    r.ff = ff;
    r.irq = 1'b0;
    nxt = (cnt + 16'h0001) & top;
    if (!run) begin
      // stopped: counter clear, flip-flop preset, width loaded for start
      r.cnt = 16'h0000; // RL7
      r.ff = ffctl; // RL11
      r.shd = pw;
    end else if (tick) begin
      case (kind)
        DCTC_TIMER: begin
          // match clears and carries on counting
          if (nxt == per) begin
            r.cnt = 16'h0000; // RL14
            r.irq = 1'b1; // RL14
          end else begin
            r.cnt = nxt; // RL14
          end
        end
        DCTC_DIVOUT: begin
          // each match flips the output: half period per match
          if (nxt == per) begin
            r.cnt = 16'h0000;
            r.irq = 1'b1;
            r.ff = ~ff;
          end else begin
            r.cnt = nxt;
          end
        end
        DCTC_PWM: begin
          // width takes effect only at a cycle boundary, so a running rewrite is glitch free
          r.cnt = nxt;
          if (cnt == top) begin
            r.ff = ffctl;
            r.irq = 1'b1;
            r.shd = pw;
          end else if (nxt == shd) begin
            r.ff = ~ffctl;
          end
        end
        DCTC_PULSEGEN: begin
          // width match flips level, period match restores it
          if (nxt == per) begin
            r.cnt = 16'h0000;
            r.irq = 1'b1;
            r.ff = ffctl;
          end else begin
            r.cnt = nxt;
            if (nxt == pw) begin
              r.ff = ~ffctl;
            end
          end
        end
        default: r.cnt = cnt;
      endcase
    end
    return r;
  endfunction

  // next state
  always_comb begin
    logic cascade;
    logic tick_a;
    logic tick_b;
    logic [1:0] ev;
    logic [1:0] clr;
    dctc_step_t sa;
    dctc_step_t sb;
    dctc_step_t s16;
    cascade = 1'b0;
    tick_a = 1'b0;
    tick_b = 1'b0;
    ev = 2'h0;
    clr = 2'h0;
    sa = '0;
    sb = '0;
    s16 = '0;
    st_d = st_q;
    st_d.rdata = '0;

    // register writes
    if (wr) begin
      unique case (addr)
        dctc_pkg::OFS_A_CONTROL: st_d.a_control = wdata[7:0]; // RL1
        dctc_pkg::OFS_A_PERIOD: st_d.a_period = wdata[7:0]; // RL1
        dctc_pkg::OFS_A_PULSE_WIDTH: st_d.a_pulse_width = wdata[7:0]; // RL1
        dctc_pkg::OFS_B_CONTROL: st_d.b_control = wdata[7:0]; // RL2
        dctc_pkg::OFS_B_PERIOD: st_d.b_period = wdata[7:0]; // RL2
        dctc_pkg::OFS_B_PULSE_WIDTH: st_d.b_pulse_width = wdata[7:0]; // RL2
        dctc_pkg::OFS_INT_STATUS: clr = wdata[1:0];
        dctc_pkg::OFS_INT_MASK: st_d.msk = wdata[1:0];
        dctc_pkg::OFS_GLOBAL_CFG: st_d.half = wdata[dctc_pkg::GCFG_HALF_BIT];
        default: st_d.half = st_q.half; // unmapped write ignored
      endcase
    end

    // cascade when channel a's mode field holds the 16-bit code
    cascade = st_q.a_control[dctc_pkg::CTL_MODE_LSB +: 3] == dctc_pkg::MODE_CASCADE; // RL8 RL9

    // clock sources; cascaded pair runs from channel a's select
    tick_a = pick_tick(st_q.a_control[dctc_pkg::CTL_CK_LSB +: 3], st_q.half, tk.tick, pin_a_rise); // RL6
    tick_b = cascade ? tick_a // RL10
                     : pick_tick(st_q.b_control[dctc_pkg::CTL_CK_LSB +: 3], st_q.half, tk.tick, pin_b_rise); // RL6

    // independent 8-bit channels
    sa = step(kind8(st_q.a_control[dctc_pkg::CTL_MODE_LSB +: 3]), // RL8
              st_q.a_control[dctc_pkg::CTL_RUN_BIT], tick_a, dctc_pkg::TOP8, // RL7
              {8'h00, st_q.a_cnt}, {8'h00, st_q.a_period}, {8'h00, st_q.a_pulse_width},
              {8'h00, st_q.a_shadow}, st_q.a_ff, st_q.a_control[dctc_pkg::CTL_FF_BIT]);
    sb = step(kind8(st_q.b_control[dctc_pkg::CTL_MODE_LSB +: 3]), // RL15
              st_q.b_control[dctc_pkg::CTL_RUN_BIT], tick_b, dctc_pkg::TOP8, // RL7
              {8'h00, st_q.b_cnt}, {8'h00, st_q.b_period}, {8'h00, st_q.b_pulse_width},
              {8'h00, st_q.b_shadow}, st_q.b_ff, st_q.b_control[dctc_pkg::CTL_FF_BIT]);

    // cascaded pair: b is the upper byte, run and flip-flop from b's control
    s16 = step(kind16(st_q.b_control[dctc_pkg::CTL_MODE_LSB +: 3]), // RL15
               st_q.b_control[dctc_pkg::CTL_RUN_BIT], tick_a, dctc_pkg::TOP16, // RL10
               {st_q.b_cnt, st_q.a_cnt}, {st_q.b_period, st_q.a_period}, // RL17
               {st_q.b_pulse_width, st_q.a_pulse_width}, {st_q.b_shadow, st_q.a_shadow},
               st_q.b_ff, st_q.b_control[dctc_pkg::CTL_FF_BIT]); // RL10 RL11

    if (cascade) begin
      // low byte overflow carries into b through the 16-bit sum
      st_d.a_cnt = s16.cnt[7:0]; // RL17
      st_d.b_cnt = s16.cnt[15:8]; // RL17
      st_d.a_shadow = s16.shd[7:0];
      st_d.b_shadow = s16.shd[15:8];
      st_d.b_ff = s16.ff;
      st_d.a_ff = st_q.a_control[dctc_pkg::CTL_FF_BIT]; // RL11
      ev[dctc_pkg::IRQ_B_BIT] = s16.irq;
    end else begin
      st_d.a_cnt = sa.cnt[7:0]; // RL17
      st_d.b_cnt = sb.cnt[7:0]; // RL17
      st_d.a_shadow = sa.shd[7:0];
      st_d.b_shadow = sb.shd[7:0];
      st_d.a_ff = sa.ff;
      st_d.b_ff = sb.ff;
      ev[dctc_pkg::IRQ_A_BIT] = sa.irq;
      ev[dctc_pkg::IRQ_B_BIT] = sb.irq;
    end

    // sticky events, write one to clear, a new event beats the clear
    st_d.sts = (st_q.sts & ~clr) | ev;
    st_d.irq = |(st_d.sts & st_d.msk);

    // read data valid the cycle after the strobe only
    if (rd) begin
      case (addr)
        dctc_pkg::OFS_A_CONTROL: st_d.rdata = {24'h000000, st_q.a_control};
        dctc_pkg::OFS_A_PERIOD: st_d.rdata = {24'h000000, st_q.a_period};
        dctc_pkg::OFS_A_PULSE_WIDTH: st_d.rdata = {24'h000000, st_q.a_pulse_width};
        dctc_pkg::OFS_B_CONTROL: st_d.rdata = {24'h000000, st_q.b_control};
        dctc_pkg::OFS_B_PERIOD: st_d.rdata = {24'h000000, st_q.b_period};
        dctc_pkg::OFS_B_PULSE_WIDTH: st_d.rdata = {24'h000000, st_q.b_pulse_width};
        dctc_pkg::OFS_INT_STATUS: st_d.rdata = {30'h00000000, st_q.sts};
        dctc_pkg::OFS_INT_MASK: st_d.rdata = {30'h00000000, st_q.msk};
        dctc_pkg::OFS_GLOBAL_CFG: st_d.rdata = {31'h00000000, st_q.half};
        dctc_pkg::OFS_COUNT_STATE: st_d.rdata = {14'h0000, st_q.b_ff, st_q.a_ff, st_q.b_cnt, st_q.a_cnt};
        default: st_d.rdata = '0; // unmapped reads as zero
      endcase
    end
  end

  // single state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign rdata = st_q.rdata;
  assign channel_a_out = st_q.a_ff;
  assign channel_b_out = st_q.b_ff;
  assign irq = st_q.irq;

endmodule

//--- verif/dctc_sva.sv
// Purpose: port-level checks for the dual cascadable timer block
// Assumes: writes seen at the register port mirror the design's registers
// Notes: shadow copies of control, period, mask and config feed the checks
`timescale 1ns/1ps
module dctc_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [dctc_pkg::ADDR_W-1:0] addr,
  input wire logic [dctc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [dctc_pkg::DATA_W-1:0] rdata,
  // pins, flip-flops, interrupt
  input wire logic channel_a_pin,
  input wire logic channel_b_pin,
  input wire logic channel_a_out,
  input wire logic channel_b_out,
  input wire logic irq
);
  logic [7:0] a_ctl_q, b_ctl_q, a_per_q;
  logic [1:0] msk_q;
  logic half_q, casc, a_stop, b_stop;

  // shadows update on the same edge that the design takes a write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      a_ctl_q <= 8'h00;
      b_ctl_q <= 8'h00;
      a_per_q <= 8'h00;
      msk_q <= 2'h0;
      half_q <= 1'b0;
    end else if (wr) begin
      case (addr)
        dctc_pkg::OFS_A_CONTROL: a_ctl_q <= wdata[7:0];
        dctc_pkg::OFS_B_CONTROL: b_ctl_q <= wdata[7:0];
        dctc_pkg::OFS_A_PERIOD: a_per_q <= wdata[7:0];
        dctc_pkg::OFS_INT_MASK: msk_q <= wdata[1:0];
        dctc_pkg::OFS_GLOBAL_CFG: half_q <= wdata[0];
        default: ;
      endcase
    end
  end

  // in cascade the low byte obeys channel b's run bit
  assign casc = a_ctl_q[2:0] == dctc_pkg::MODE_CASCADE;
  assign a_stop = casc ? !b_ctl_q[3] : !a_ctl_q[3];
  assign b_stop = !b_ctl_q[3];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_read_quiet: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  chk_count_a_clear: assert property (rd && addr == dctc_pkg::OFS_COUNT_STATE && a_stop && $past(a_stop)
    |=> rdata[7:0] == 8'h00) else $error("stopped low counter not cleared");
  chk_count_b_clear: assert property (rd && addr == dctc_pkg::OFS_COUNT_STATE && b_stop && $past(b_stop)
    |=> rdata[15:8] == 8'h00) else $error("stopped high counter not cleared");
  chk_a_ff_preset: assert property ((casc || !a_ctl_q[3]) && $stable(a_ctl_q)
    |-> channel_a_out == a_ctl_q[7]) else $error("channel a flip-flop not at preset level");
  chk_b_ff_preset: assert property (b_stop && $stable(b_ctl_q) |-> channel_b_out == b_ctl_q[7])
    else $error("channel b flip-flop not at preset level");
  chk_irq_masked: assert property (msk_q == 2'h0 |-> !irq)
    else $error("interrupt high with all sources masked");
  chk_status_cause: assert property (rd && addr == dctc_pkg::OFS_INT_STATUS && irq
    |=> (rdata[1:0] & msk_q) != 2'h0) else $error("interrupt high without an unmasked status bit");
  chk_timer_fires: assert property (!half_q && a_ctl_q == 8'h38 && a_per_q == 8'h02 && msk_q == 2'h1
    |-> ##[0:20] irq) else $error("fast timer match did not raise the interrupt");
endmodule

bind dctc_top dctc_sva chk (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .channel_a_pin, .channel_b_pin,
  .channel_a_out, .channel_b_out, .irq);

//--- verif/testbench.sv
// Purpose: self-checking bench for the dual cascadable timer block
// Assumes: reads answer one cycle after the strobe, the port never stalls
// Notes: reads queue their expectation; a monitor compares when data appear
`timescale 1ns/1ps
module testbench;
  logic clock;
  logic rstn = 1'b0, wr = 1'b0, rd = 1'b0, pin_a = 1'b0, pin_b = 1'b0, rd_seen = 1'b0;
  logic [dctc_pkg::ADDR_W-1:0] addr = 8'h00;
  logic [dctc_pkg::DATA_W-1:0] wdata = 32'h0, rdata;
  logic out_a, out_b, irq;
  logic [31:0] exp_list[$], msk_list[$];
  logic [7:0] ctl_a, ctl_b;
  logic [7:0] cmp_regs[4] = '{dctc_pkg::OFS_A_PERIOD, dctc_pkg::OFS_A_PULSE_WIDTH, dctc_pkg::OFS_B_PERIOD,
    dctc_pkg::OFS_B_PULSE_WIDTH};
  int mismatches = 0, num_checks = 0, cyc = 0, i, k, ta;
  logic [31:0] d;

  // both pins pulse together in the event counting test
  dctc_top dut (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .channel_a_pin(pin_a), .channel_b_pin(pin_b),
    .channel_a_out(out_a), .channel_b_out(out_b), .irq);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // read data stand only in the cycle after the strobe, so compare there
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rd_seen) begin
      cmp_read(rdata & msk_list.pop_front(), exp_list.pop_front());
    end
    rd_seen <= rd;
  end

  task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t output %0d expected %0d", $time, got, exp);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // strobes are left up so operations can run back to back; nop drops them
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clock);
    addr <= a;
    wdata <= dat;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    exp_list.push_back(e & m);
    msk_list.push_back(m);
  endtask

  task automatic nop;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 20000);
    if (irq !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t interrupt never came", $time);
      summarize();
    end
    t = cyc;
  endtask

  // spacing of two events; the phase of the first one does not matter
  task automatic gap(input int e);
    int t0, t1;
    wr_reg(dctc_pkg::OFS_INT_STATUS, 32'h3);
    nop();
    wait_irq(t0);
    wr_reg(dctc_pkg::OFS_INT_STATUS, 32'h3);
    nop();
    wait_irq(t1);
    cmp_out(t1 - t0, e);
  endtask

  // pulses stay well above the two-clock minimum
  task automatic pulse;
    nop();
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    repeat (4) @(posedge clock);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  initial begin
    void'($urandom(32'h65b8));
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (i = 0; i <= 9; i++) begin
      rd_reg(8'(i * 4), 32'h0, 32'hFFFF_FFFF);
    end
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      wr_reg(cmp_regs[i], d);
      rd_reg(cmp_regs[i], d, 32'hFF);
      ctl_a = 8'($urandom) & 8'hF7;
      ctl_b = 8'($urandom) & 8'hF7;
      wr_reg(dctc_pkg::OFS_A_CONTROL, {24'h0, ctl_a});
      wr_reg(dctc_pkg::OFS_B_CONTROL, {24'h0, ctl_b});
      rd_reg(dctc_pkg::OFS_A_CONTROL, {24'h0, ctl_a}, 32'hFF);
      rd_reg(dctc_pkg::OFS_B_CONTROL, {24'h0, ctl_b}, 32'hFF);
      nop();
      #1;
      cmp_out({out_b, out_a}, {ctl_b[7], ctl_a[7]});
    end
    wr_reg(8'h28, $urandom);
    rd_reg(8'h28, 32'h0, 32'hFFFF_FFFF);
    $display("test registers done");
    // every clock-select tap at both divider settings, period two
    wr_reg(dctc_pkg::OFS_A_PERIOD, 32'h2);
    wr_reg(dctc_pkg::OFS_INT_MASK, 32'h1);
    for (i = 0; i < 8; i++) begin
      k = i % 4;
      wr_reg(dctc_pkg::OFS_A_CONTROL, {24'h0, ctl_a & 8'hF7});
      wr_reg(dctc_pkg::OFS_GLOBAL_CFG, i / 4);
      ctl_a = {1'b0, 3'(k), 1'b1, dctc_pkg::MODE_TIMER};
      wr_reg(dctc_pkg::OFS_A_CONTROL, {24'h0, ctl_a});
      gap(2 << ((k == 0 ? 11 : 9 - 2 * k) + i / 4));
    end
    wr_reg(dctc_pkg::OFS_A_CONTROL, {24'h0, ctl_a & 8'hF7});
    wr_reg(dctc_pkg::OFS_GLOBAL_CFG, 32'h0);
    nop();
    rd_reg(dctc_pkg::OFS_COUNT_STATE, 32'h0, 32'hFF);
    $display("test prescaler done");
    // both channels count pin edges, period three
    wr_reg(dctc_pkg::OFS_A_PERIOD, 32'h3);
    wr_reg(dctc_pkg::OFS_B_PERIOD, 32'h3);
    wr_reg(dctc_pkg::OFS_INT_MASK, 32'h2);
    wr_reg(dctc_pkg::OFS_INT_STATUS, 32'h3);
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h78);
    wr_reg(dctc_pkg::OFS_B_CONTROL, 32'h78);
    for (i = 1; i <= 3; i++) begin
      pulse();
      rd_reg(dctc_pkg::OFS_COUNT_STATE, {16'h0, 8'(i % 3), 8'(i % 3)}, 32'hFFFF);
      rd_reg(dctc_pkg::OFS_INT_STATUS, {30'h0, i == 3, i == 3}, 32'h3);
    end
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h70);
    wr_reg(dctc_pkg::OFS_B_CONTROL, 32'h70);
    $display("test pin done");
    // divider output toggles per match; PWM drops at wrap, rises at width
    wr_reg(dctc_pkg::OFS_A_PERIOD, 32'h1);
    wr_reg(dctc_pkg::OFS_INT_MASK, 32'h1);
    wr_reg(dctc_pkg::OFS_INT_STATUS, 32'h3);
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h39);
    for (i = 1; i >= 0; i--) begin
      nop();
      wait_irq(ta);
      cmp_out(out_a, i);
      wr_reg(dctc_pkg::OFS_INT_STATUS, 32'h3);
    end
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h31);
    wr_reg(dctc_pkg::OFS_A_PULSE_WIDTH, 32'h2);
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h3A);
    nop();
    wait_irq(ta);
    cmp_out(out_a, 0);
    repeat (20) @(posedge clock);
    #1;
    cmp_out(out_a, 1);
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h32);
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h3C);
    nop();
    repeat (40) @(posedge clock);
    rd_reg(dctc_pkg::OFS_COUNT_STATE, 32'h0, 32'hFF);
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h34);
    $display("test divider pwm done");
    // cascade: 16-bit period 0x0100, tap from a, run from b
    wr_reg(dctc_pkg::OFS_A_CONTROL, 32'h33);
    wr_reg(dctc_pkg::OFS_A_PERIOD, 32'h0);
    wr_reg(dctc_pkg::OFS_B_PERIOD, 32'h1);
    wr_reg(dctc_pkg::OFS_A_PULSE_WIDTH, 32'h10);
    wr_reg(dctc_pkg::OFS_B_PULSE_WIDTH, 32'h0);
    wr_reg(dctc_pkg::OFS_INT_MASK, 32'h2);
    for (k = 4; k < 8; k++) begin
      if (k > 4) begin
        wr_reg(dctc_pkg::OFS_B_CONTROL, k - 1);
      end
      wr_reg(dctc_pkg::OFS_B_CONTROL, 8 | k);
      if (k == 6) begin
        wr_reg(dctc_pkg::OFS_INT_STATUS, 32'h3);
        nop();
        repeat (2100) @(posedge clock);
        rd_reg(dctc_pkg::OFS_INT_STATUS, 32'h0, 32'h2);
      end else begin
        gap(2048);
      end
    end
    wr_reg(dctc_pkg::OFS_B_CONTROL, 32'h7);
    nop();
    rd_reg(dctc_pkg::OFS_COUNT_STATE, 32'h0, 32'hFFFF);
    $display("test cascade done");
    nop();
    nop();
    nop();
    summarize();
  end
endmodule
